/* File: rtl/vfa_pkg.sv */
// Constants for the display configuration and annunciator control block
package vfa_pkg;
  // Command addresses seen by the serial front end
  localparam logic [7:0] VFA_CFG_ADDR = 8'h04;
  localparam logic [7:0] VFA_ANN_BASE = 8'h60;
  localparam int VFA_ANN_BYTES = 16;
  localparam logic [7:0] VFA_ANN_LAST = 8'h6F;
  localparam logic [7:0] VFA_CLR_LO = 8'h20;
  localparam logic [7:0] VFA_CLR_HI = 8'h7F;
  localparam logic [7:0] VFA_RD_NONE = 8'h00;

  // Configuration field positions
  localparam int VFA_CFG_RUN = 0;
  localparam int VFA_CFG_LOCK = 1;
  localparam int VFA_CFG_FAST = 2;
  localparam int VFA_CFG_IGNORED = 3;
  localparam int VFA_CFG_SYNC = 4;
  localparam int VFA_CFG_CLEAR = 5;
  localparam int VFA_CFG_DUAL = 6;
  localparam int VFA_CFG_PHASE = 7;

  // Reset values
  localparam logic [7:0] VFA_CFG_RESET = 8'h00;
  localparam logic [7:0] VFA_ANN_RESET = 8'h00;

  // Annunciator field encodings
  localparam logic [1:0] VFA_IND_OFF = 2'h0;
  localparam logic [1:0] VFA_IND_FIRST = 2'h1;
  localparam logic [1:0] VFA_IND_SECOND = 2'h2;
  localparam logic [1:0] VFA_IND_STEADY = 2'h3;

  // Blink timing
  localparam int VFA_CLK_HZ = 10000000;
  localparam int VFA_SLOW_HALF_MS = 1000;
  localparam int VFA_FAST_HALF_MS = 500;
  localparam int VFA_SLOW_HALF_CYC = VFA_SLOW_HALF_MS * (VFA_CLK_HZ / 1000);
  localparam int VFA_FAST_HALF_CYC = VFA_FAST_HALF_MS * (VFA_CLK_HZ / 1000);
  localparam int VFA_CNT_W = 24;
endpackage : vfa_pkg

/* File: rtl/vfa_blink_if.sv */
// Link between the control block and its shared blink timebase
`timescale 1ns/100ps
interface vfa_blink_if;
  logic fast;
  logic sync;
  logic phase;
  modport ctrl (output fast, output sync, input phase);
  modport timer (input fast, input sync, output phase);
endinterface : vfa_blink_if

/* File: rtl/vfa_blink_timer.sv */
// Shared blink timebase for cursor and annunciators
`timescale 1ns/100ps
module vfa_blink_timer
  import vfa_pkg::*;
#(
  parameter int SLOW_HALF = VFA_SLOW_HALF_CYC,
  parameter int FAST_HALF = VFA_FAST_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control side
  vfa_blink_if.timer blink
);
  localparam logic [VFA_CNT_W-1:0] SLOW_LAST = VFA_CNT_W'(SLOW_HALF - 1);
  localparam logic [VFA_CNT_W-1:0] FAST_LAST = VFA_CNT_W'(FAST_HALF - 1);

  logic [VFA_CNT_W-1:0] cnt_r;
  logic [VFA_CNT_W-1:0] cnt_nxt;
  logic phase_r;
  logic phase_nxt;
  wire logic [VFA_CNT_W-1:0] half_last = blink.fast ? FAST_LAST : SLOW_LAST; // [RULE6]
  wire logic wrap = (cnt_r >= half_last);

  // Sync restarts the first half from zero
  assign cnt_nxt = (blink.sync || wrap) ? '0 : cnt_r + 1'b1; // [RULE7]
  assign phase_nxt = blink.sync ? 1'b0 : (wrap ? ~phase_r : phase_r); // [RULE7]

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      phase_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign blink.phase = phase_r; // [RULE12]

  chk_sync_restarts_phase: assert property (@(posedge clk) disable iff (rst) // [RULE7]
    blink.sync |=> (phase_r == 1'b0) && (cnt_r == '0))
    else $error("blink sync did not restart the timebase");

  chk_phase_toggle_wrap: assert property (@(posedge clk) disable iff (rst) // [RULE6]
    (!blink.sync && wrap) |=> (phase_r != $past(phase_r)))
    else $error("blink phase did not toggle at half period end");

  chk_phase_stable_mid: assert property (@(posedge clk) disable iff (rst) // [RULE6]
    (!blink.sync && !wrap) |=> $stable(phase_r) && (cnt_r == $past(cnt_r) + 1'b1))
    else $error("blink phase changed inside a half period");
endmodule : vfa_blink_timer

/* File: rtl/vfa_ctrl.sv */
// Configuration register and annunciator control for the display controller
//
// Contract
// RULE1: Annunciator byte holds four 2-bit fields.
// RULE2: 00 keeps dark, 11 lights steadily.
// RULE3: 01 lights first half, 10 second half.
// RULE4: Config bit 0: 0 shutdown, 1 run.
// RULE5: Config bit 1 holds lock state.
// RULE6: Config bit 2 selects slow or fast blink.
// RULE7: Writing bit 4 one restarts blink timers.
// RULE8: Writing bit 5 one clears display data.
// RULE9: Config bit 6 selects one or two digits.
// RULE10: Config bit 3 is ignored.
// RULE11: Readback bit 7 shows blink phase.
// RULE12: Cursor and annunciators share one timebase.
`timescale 1ns/100ps
module vfa_ctrl
  import vfa_pkg::*;
#(
  parameter int SLOW_HALF = VFA_SLOW_HALF_CYC,
  parameter int FAST_HALF = VFA_FAST_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register writes, applied at the acknowledge of the data byte
  input wire logic wr_ack,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Register reads
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Configuration state
  output logic normal_mode,
  output logic cfg_locked,
  output logic fast_blink,
  output logic two_digit_mode,
  // Shared blink timebase and one-cycle actions
  output logic blink_phase,
  output logic cursor_phase,
  output logic blink_sync_pulse,
  output logic seg_clear_pulse,
  // Annunciator drive, four per byte
  output logic [VFA_ANN_BYTES*4-1:0] indicator_lit
);
  localparam int ANN_IDX_W = $clog2(VFA_ANN_BYTES);

  // Storage
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [7:0] ann_r [VFA_ANN_BYTES];
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  logic sync_r;
  logic clear_r;
  logic [VFA_ANN_BYTES*4-1:0] lit_r;

  vfa_blink_if blink ();

  // Address decode
  wire logic cfg_hit_w = (wr_addr == VFA_CFG_ADDR);
  wire logic ann_hit_w = (wr_addr >= VFA_ANN_BASE) && (wr_addr <= VFA_ANN_LAST);
  wire logic cfg_wr = wr_ack && cfg_hit_w;
  wire logic ann_wr = wr_ack && ann_hit_w;
  wire logic [7:0] ann_off_w = wr_addr - VFA_ANN_BASE;
  wire logic [ANN_IDX_W-1:0] ann_wr_idx = ann_off_w[ANN_IDX_W-1:0];
  wire logic cfg_rd_hit = (rd_addr == VFA_CFG_ADDR);
  wire logic ann_rd_hit = (rd_addr >= VFA_ANN_BASE) && (rd_addr <= VFA_ANN_LAST);
  wire logic [7:0] ann_rd_off = rd_addr - VFA_ANN_BASE;
  wire logic [ANN_IDX_W-1:0] ann_rd_idx = ann_rd_off[ANN_IDX_W-1:0];

  // Action bits act during the acknowledge and are not stored
  wire logic sync_req = cfg_wr && wr_data[VFA_CFG_SYNC]; // [RULE7]
  wire logic clear_req = cfg_wr && wr_data[VFA_CFG_CLEAR]; // [RULE8]
  // Annunciator bytes sit inside the cleared range
  wire logic ann_in_clear = (VFA_ANN_BASE >= VFA_CLR_LO) && (VFA_ANN_LAST <= VFA_CLR_HI);

  // Stored configuration: run, lock, rate and mode; bit 3 dropped
  always_comb begin
    cfg_nxt = cfg_r;
    if (cfg_wr) begin
      cfg_nxt[VFA_CFG_RUN] = wr_data[VFA_CFG_RUN]; // [RULE4]
      cfg_nxt[VFA_CFG_LOCK] = wr_data[VFA_CFG_LOCK]; // [RULE5]
      cfg_nxt[VFA_CFG_FAST] = wr_data[VFA_CFG_FAST]; // [RULE6]
      cfg_nxt[VFA_CFG_DUAL] = wr_data[VFA_CFG_DUAL]; // [RULE9]
      cfg_nxt[VFA_CFG_IGNORED] = 1'b0; // [RULE10]
      cfg_nxt[VFA_CFG_SYNC] = 1'b0;
      cfg_nxt[VFA_CFG_CLEAR] = 1'b0;
      cfg_nxt[VFA_CFG_PHASE] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= VFA_CFG_RESET;
      sync_r <= 1'b0;
      clear_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      sync_r <= sync_req;
      clear_r <= clear_req;
    end
  end

  // Shared blink timebase
  assign blink.fast = cfg_r[VFA_CFG_FAST]; // [RULE6]
  assign blink.sync = sync_req; // [RULE7]

  vfa_blink_timer #(
    .SLOW_HALF(SLOW_HALF),
    .FAST_HALF(FAST_HALF)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .blink(blink.timer)
  );

  // Annunciator bytes and their decode
  genvar gb;
  genvar gf;
  generate
    for (gb = 0; gb < VFA_ANN_BYTES; gb++) begin : g_byte
      wire logic this_wr = ann_wr && (ann_wr_idx == ANN_IDX_W'(gb));
      always_ff @(posedge clk) begin
        if (rst) begin
          ann_r[gb] <= VFA_ANN_RESET;
        end else if (clear_req && ann_in_clear) begin
          ann_r[gb] <= VFA_ANN_RESET; // [RULE8]
        end else if (this_wr) begin
          ann_r[gb] <= wr_data;
        end
      end
      for (gf = 0; gf < 4; gf++) begin : g_field
        // Field gf of byte gb lives in bits 2*gf+1 : 2*gf
        wire logic [1:0] fld = ann_r[gb][2*gf+1:2*gf]; // [RULE1]
        wire logic on_w = (fld == VFA_IND_STEADY) || // [RULE2]
                          ((fld == VFA_IND_FIRST) && !blink.phase) || // [RULE3]
                          ((fld == VFA_IND_SECOND) && blink.phase); // [RULE3]
        always_ff @(posedge clk) begin
          if (rst) begin
            lit_r[gb*4+gf] <= 1'b0;
          end else begin
            lit_r[gb*4+gf] <= on_w && cfg_r[VFA_CFG_RUN]; // [RULE4]
          end
        end
      end
    end
  endgenerate

  // Readback with the live blink phase in bit 7
  wire logic [7:0] cfg_view = {blink.phase, cfg_r[6:0]}; // [RULE11]
  wire logic [7:0] rd_mux = cfg_rd_hit ? cfg_view :
                            (ann_rd_hit ? ann_r[ann_rd_idx] : VFA_RD_NONE);

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_en;
      if (rd_en) begin
        rd_data_r <= rd_mux;
      end
    end
  end

  // Outputs
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign normal_mode = cfg_r[VFA_CFG_RUN]; // [RULE4]
  assign cfg_locked = cfg_r[VFA_CFG_LOCK]; // [RULE5]
  assign fast_blink = cfg_r[VFA_CFG_FAST];
  assign two_digit_mode = cfg_r[VFA_CFG_DUAL]; // [RULE9]
  assign blink_phase = blink.phase;
  assign cursor_phase = blink.phase; // [RULE12]
  assign blink_sync_pulse = sync_r;
  assign seg_clear_pulse = clear_r; // [RULE8]
  assign indicator_lit = lit_r;

  // Checks
  chk_field_dark: assert property (@(posedge clk) disable iff (rst) // [RULE2]
    (ann_r[0][1:0] == VFA_IND_OFF) |=> !indicator_lit[0])
    else $error("dark field lit its annunciator");

  chk_field_steady: assert property (@(posedge clk) disable iff (rst) // [RULE2]
    (ann_r[0][7:6] == VFA_IND_STEADY && cfg_r[VFA_CFG_RUN]) |=> indicator_lit[3])
    else $error("steady field not lit");

  chk_first_half: assert property (@(posedge clk) disable iff (rst) // [RULE3]
    (ann_r[1][3:2] == VFA_IND_FIRST && cfg_r[VFA_CFG_RUN])
      |=> (indicator_lit[5] == !$past(blink_phase)))
    else $error("first-half field lit in wrong phase");

  chk_second_half: assert property (@(posedge clk) disable iff (rst) // [RULE3]
    (ann_r[1][5:4] == VFA_IND_SECOND && cfg_r[VFA_CFG_RUN])
      |=> (indicator_lit[6] == $past(blink_phase)))
    else $error("second-half field lit in wrong phase");

  chk_field_position: assert property (@(posedge clk) disable iff (rst) // [RULE1]
    (ann_wr && ann_wr_idx == '0 && !clear_req && wr_data == 8'h0C && cfg_r[VFA_CFG_RUN]
      && cfg_nxt[VFA_CFG_RUN])
      |=> ##1 (indicator_lit[3:0] == 4'h2))
    else $error("annunciator field positions wrong");

  chk_shutdown_dark: assert property (@(posedge clk) disable iff (rst) // [RULE4]
    !normal_mode |=> (indicator_lit == '0))
    else $error("annunciator lit in shutdown");

  chk_cfg_store: assert property (@(posedge clk) disable iff (rst) // [RULE5]
    cfg_wr |=> (cfg_locked == $past(wr_data[VFA_CFG_LOCK]))
      && (normal_mode == $past(wr_data[VFA_CFG_RUN]))
      && (two_digit_mode == $past(wr_data[VFA_CFG_DUAL]))
      && (fast_blink == $past(wr_data[VFA_CFG_FAST])))
    else $error("configuration write not stored");

  chk_bit3_ignored: assert property (@(posedge clk) disable iff (rst) // [RULE10]
    cfg_wr |=> (cfg_r[VFA_CFG_IGNORED] == 1'b0))
    else $error("ignored configuration bit was stored");

  chk_sync_pulse: assert property (@(posedge clk) disable iff (rst) // [RULE7]
    sync_req |=> blink_sync_pulse && !blink_phase)
    else $error("sync write did not restart blink phase");

  chk_clear_data: assert property (@(posedge clk) disable iff (rst) // [RULE8]
    clear_req |=> seg_clear_pulse && (ann_r[VFA_ANN_BYTES-1] == VFA_ANN_RESET)
      && (ann_r[0] == VFA_ANN_RESET))
    else $error("global clear did not clear display data");

  chk_no_clear_zero: assert property (@(posedge clk) disable iff (rst) // [RULE8]
    (cfg_wr && !wr_data[VFA_CFG_CLEAR]) |=> !seg_clear_pulse)
    else $error("clear fired without its bit");

  chk_phase_readback: assert property (@(posedge clk) disable iff (rst) // [RULE11]
    (rd_en && cfg_rd_hit) |=> rd_valid && (rd_data[7] == $past(blink_phase)))
    else $error("readback bit 7 does not match blink phase");

  chk_shared_phase: assert property (@(posedge clk) disable iff (rst) // [RULE12]
    cursor_phase == blink_phase)
    else $error("cursor and annunciator phases differ");

  chk_run_hold: assert property (@(posedge clk) disable iff (rst) // [RULE4]
    !cfg_wr |=> $stable(normal_mode))
    else $error("power state changed without a configuration write");

  chk_lock_hold: assert property (@(posedge clk) disable iff (rst) // [RULE5]
    !cfg_wr |=> $stable(cfg_locked))
    else $error("lock state changed without a configuration write");

  chk_rate_hold: assert property (@(posedge clk) disable iff (rst) // [RULE6]
    !cfg_wr |=> $stable(fast_blink))
    else $error("blink rate changed without a configuration write");

  chk_mode_hold: assert property (@(posedge clk) disable iff (rst) // [RULE9]
    !cfg_wr |=> $stable(two_digit_mode))
    else $error("display mode changed without a configuration write");

  chk_no_sync_zero: assert property (@(posedge clk) disable iff (rst) // [RULE7]
    (cfg_wr && !wr_data[VFA_CFG_SYNC]) |=> !blink_sync_pulse)
    else $error("sync fired without its bit");

  chk_sync_cause: assert property (@(posedge clk) disable iff (rst) // [RULE7]
    blink_sync_pulse |-> $past(sync_req))
    else $error("sync pulse without a sync write");

  chk_clear_zero_keeps: assert property (@(posedge clk) disable iff (rst) // [RULE8]
    (cfg_wr && !wr_data[VFA_CFG_CLEAR])
      |=> $stable(ann_r[0]) && $stable(ann_r[VFA_ANN_BYTES-1]))
    else $error("annunciator data changed without clear bit");

  chk_clear_cause: assert property (@(posedge clk) disable iff (rst) // [RULE8]
    seg_clear_pulse |-> $past(clear_req))
    else $error("clear pulse without a clear write");

  chk_ann_store_first: assert property (@(posedge clk) disable iff (rst) // [RULE1]
    (ann_wr && ann_wr_idx == '0 && !clear_req) |=> (ann_r[0] == $past(wr_data)))
    else $error("first annunciator byte not stored");

  chk_ann_store_last: assert property (@(posedge clk) disable iff (rst) // [RULE1]
    (ann_wr && ann_wr_idx == ANN_IDX_W'(VFA_ANN_BYTES - 1) && !clear_req)
      |=> (ann_r[VFA_ANN_BYTES-1] == $past(wr_data)))
    else $error("last annunciator byte not stored");

  chk_ann_readback: assert property (@(posedge clk) disable iff (rst) // [RULE1]
    (rd_en && ann_rd_hit && ann_rd_idx == '0)
      |=> rd_valid && (rd_data == $past(ann_r[0])))
    else $error("annunciator readback wrong");

  chk_cfg_read_bits: assert property (@(posedge clk) disable iff (rst) // [RULE10]
    (rd_en && cfg_rd_hit) |=> (rd_data[VFA_CFG_IGNORED] == 1'b0)
      && (rd_data[VFA_CFG_SYNC] == 1'b0) && (rd_data[VFA_CFG_CLEAR] == 1'b0))
    else $error("unstored configuration bits read back set");

  chk_steady_last: assert property (@(posedge clk) disable iff (rst) // [RULE2]
    (ann_r[VFA_ANN_BYTES-1][1:0] == VFA_IND_STEADY && cfg_r[VFA_CFG_RUN])
      |=> indicator_lit[VFA_ANN_BYTES*4-4])
    else $error("steady field of last byte not lit");

  chk_dark_last: assert property (@(posedge clk) disable iff (rst) // [RULE2]
    (ann_r[VFA_ANN_BYTES-1][7:6] == VFA_IND_OFF) |=> !indicator_lit[VFA_ANN_BYTES*4-1])
    else $error("dark field of last byte lit");

  chk_read_valid: assert property (@(posedge clk) disable iff (rst) // [RULE11]
    rd_en |=> rd_valid)
    else $error("read request not answered");

  chk_read_idle: assert property (@(posedge clk) disable iff (rst) // [RULE11]
    !rd_en |=> !rd_valid)
    else $error("read answer without a request");
endmodule : vfa_ctrl

/* File: verification/vfa_host_model.sv */
// Host side model issuing register writes and reads
`timescale 1ns/100ps
module vfa_host_model (
  // Clock
  input wire logic clk,
  // Write request
  output logic wr_ack,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  // Read request and answer
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    wr_ack = 1'b0;
    wr_addr = 8'hFF;
    wr_data = 8'hFF;
    rd_en = 1'b0;
    rd_addr = 8'hFF;
  end

  // One data byte, applied at its acknowledge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr_ack = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge clk);
    #1;
    wr_ack = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask : wr

  // Answer is taken in the cycle after the request; no answer gives unknown
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    rd_addr = a;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    rd_addr = ~a;
    d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
  endtask : rd
endmodule : vfa_host_model

/* File: verification/tb.sv */
// Self-checking bench for the configuration and annunciator block
`timescale 1ns/100ps
module tb;
  import vfa_pkg::*;
  localparam int SLOW = 8;
  localparam int FAST = 4;
  logic clk;
  logic rst;
  logic wr_ack;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_valid;
  logic normal_mode;
  logic cfg_locked;
  logic fast_blink;
  logic two_digit_mode;
  logic blink_phase;
  logic cursor_phase;
  logic blink_sync_pulse;
  logic seg_clear_pulse;
  logic [VFA_ANN_BYTES*4-1:0] indicator_lit;
  int miscompares;
  int comparisons;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  vfa_host_model i_host (.clk(clk), .wr_ack(wr_ack), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

  vfa_ctrl #(.SLOW_HALF(SLOW), .FAST_HALF(FAST)) i_dut (.clk(clk), .rst(rst),
    .wr_ack(wr_ack), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .normal_mode(normal_mode),
    .cfg_locked(cfg_locked), .fast_blink(fast_blink), .two_digit_mode(two_digit_mode),
    .blink_phase(blink_phase), .cursor_phase(cursor_phase),
    .blink_sync_pulse(blink_sync_pulse), .seg_clear_pulse(seg_clear_pulse),
    .indicator_lit(indicator_lit));

  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk({56'h0, d}, {56'h0, e});
  endtask : rdchk

  // Sync write, then look mid first half and mid second half
  task automatic blk(input logic [7:0] cfg, input int half, input logic [7:0] e0,
    input logic [7:0] e1);
    i_host.wr(VFA_CFG_ADDR, cfg);
    chk({normal_mode, cfg_locked, fast_blink, two_digit_mode, blink_sync_pulse,
      seg_clear_pulse}, {cfg[0], cfg[1], cfg[2], cfg[6], cfg[4], cfg[5]});
    repeat (half / 2) @(posedge clk);
    #1;
    chk({blink_phase, cursor_phase, indicator_lit[63:60], indicator_lit[3:0]}, {2'h0, e0});
    repeat (half) @(posedge clk);
    #1;
    chk({blink_phase, cursor_phase, indicator_lit[63:60], indicator_lit[3:0]}, {2'h3, e1});
  endtask : blk

  initial begin
    miscompares = 0;
    comparisons = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({normal_mode, cfg_locked, fast_blink, two_digit_mode, indicator_lit[3:0]}, 8'h00);
    rdchk(VFA_CFG_ADDR, 8'h00);
    rdchk(8'h60, 8'h00);
    rdchk(8'h05, 8'h00);
    i_host.wr(8'h60, 8'hE4);
    i_host.wr(8'h6F, 8'h1B);
    i_host.wr(8'h61, 8'h24);
    rdchk(8'h60, 8'hE4);
    rdchk(8'h6F, 8'h1B);
    blk(8'h5F, FAST, 8'h5A, 8'h3C);
    blk(8'h53, SLOW, 8'h5A, 8'h3C);
    rdchk(VFA_CFG_ADDR, 8'hC3);
    i_host.wr(VFA_CFG_ADDR, 8'h19);
    rdchk(VFA_CFG_ADDR, 8'h01);
    rdchk(8'h60, 8'hE4);
    i_host.wr(VFA_CFG_ADDR, 8'h10);
    repeat (2) @(posedge clk);
    #1;
    chk({63'h0, normal_mode}, 64'h0);
    chk(indicator_lit, 64'h0);
    i_host.wr(VFA_CFG_ADDR, 8'h21);
    chk({blink_sync_pulse, seg_clear_pulse}, 2'h1);
    rdchk(8'h60, 8'h00);
    rdchk(8'h6F, 8'h00);
    i_host.wr(8'h60, 8'h0C);
    repeat (2) @(posedge clk);
    #1;
    chk({60'h0, indicator_lit[3:0]}, 64'h2);
    final_report();
  end

  initial begin
    #(5000 * 100);
    miscompares++;
    final_report();
  end
endmodule : tb
